/* hw/zlac_pkg.sv */
// constants, types and encodings shared by the zone lock access control
package zlac_pkg;

    // ------------------------------------------------------------
    // lock byte encodings and config zone byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ZLAC_UNLOCKED = 8'h55;
    localparam logic [7:0] ZLAC_LOCKED = 8'h00;
    localparam logic [6:0] ZLAC_OFS_DATA_LOCK = 7'h56;
    localparam logic [6:0] ZLAC_OFS_CFG_LOCK = 7'h57;
    localparam logic [6:0] ZLAC_OFS_SLOT_LO = 7'h58;
    localparam logic [6:0] ZLAC_OFS_SLOT_HI = 7'h59;
    localparam logic [6:0] ZLAC_OFS_FIXED_LAST = 7'h0f;
    localparam logic [6:0] ZLAC_OFS_KEYPOL = 7'h60;
    localparam int ZLAC_LOCKABLE_BIT = 5;
    localparam int ZLAC_NSLOT = 16;

    // ------------------------------------------------------------
    // OTP mode byte values
    // ------------------------------------------------------------
    localparam logic [7:0] ZLAC_OTP_READ_ONLY = 8'haa;
    localparam logic [7:0] ZLAC_OTP_CONSUME = 8'h55;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ZLAC_RST_LOCK = 8'h00;
    localparam logic [15:0] ZLAC_RST_SLOTS = 16'h0000;

    // ------------------------------------------------------------
    // request and answer types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ZLAC_OP_READ = 4'h0,
        ZLAC_OP_WRITE = 4'h1,
        ZLAC_OP_PRIV_WRITE = 4'h2,
        ZLAC_OP_GENKEY = 4'h3,
        ZLAC_OP_DERIVE = 4'h4,
        ZLAC_OP_VERIFY = 4'h5,
        ZLAC_OP_LOCK_CFG = 4'h6,
        ZLAC_OP_LOCK_DATA = 4'h7,
        ZLAC_OP_LOCK_SLOT = 4'h8
    } zlac_op_t;

    typedef enum logic [1:0] {
        ZLAC_ZONE_CFG = 2'h0,
        ZLAC_ZONE_OTP = 2'h1,
        ZLAC_ZONE_DATA = 2'h2
    } zlac_zone_t;

    typedef enum logic [1:0] {
        ZLAC_RSP_OK = 2'h0,
        ZLAC_RSP_ERR_LOCK = 2'h1,
        ZLAC_RSP_ERR_POLICY = 2'h2,
        ZLAC_RSP_ERR_PARAM = 2'h3
    } zlac_rsp_t;

    typedef enum logic [1:0] {
        ZLAC_ST_LOAD = 2'b00,
        ZLAC_ST_READY = 2'b01
    } zlac_state_t;

    typedef struct packed {
        zlac_op_t op;
        zlac_zone_t zone;
        logic [3:0] slot;
        logic [6:0] addr;
        logic [7:0] wdata;
    } zlac_req_t;

    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] wdata;
    } zlac_nvwr_t;

endpackage

/* hw/zlac_access_ctrl.sv */
// zone and slot lock state with per-command access decision
//
// How it works
// (R1) config lock state lives in byte 87
// (R2) one lock byte 86 covers data and OTP
// (R3) lock bytes change only via lock command
// (R4) locked never returns to unlocked
// (R5) config unlocked: data/OTP access is an error
// (R6) config unlocked only when byte equals 0x55
// (R7) config writes only while config unlocked
// (R8) config reads always allowed
// (R9) fixed low config bytes never writable
// (R10) lock command updates slot bits after lock
// (R11) data unlocked: OTP and open-slot writes allowed, reads refused
// (R12) data unlocked: slot write policy bypassed
// (R13) data locked: slot policies enforced
// (R14) data locked: OTP access follows OTP mode
// (R15) 16 slot lock bits plus lockable flags
// (R16) before config lock, writes change slot bits
// (R17) slot bit 0 refuses modifying commands
// (R18) slot lock only when lockable flag set
// (R19) slot locking checks no content CRC
// (R20) verify allowed regardless of slot bit
// (R21) host locks config, writes, then locks data
// (R22) lock state loaded from storage before use
module zlac_access_ctrl
    import zlac_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // nonvolatile lock state image
    input wire logic [7:0] nv_cfg_lock_i,
    input wire logic [7:0] nv_data_lock_i,
    input wire logic [15:0] nv_slot_lock_i,
    input wire logic [15:0] nv_lockable_i,
    input wire logic [7:0] otp_mode_i,
    // per-slot policy outcome from the policy decoder
    input wire logic pol_rd_ok_i,
    input wire logic pol_wr_ok_i,
    // command request
    input wire logic req_valid_i,
    input wire zlac_req_t req_i,
    output logic req_ready_o,
    // command answer
    output logic rsp_valid_o,
    output zlac_rsp_t rsp_code_o,
    // nonvolatile write-back
    output zlac_nvwr_t nv_wr_o,
    // lock status
    output logic cfg_locked_o,
    output logic data_locked_o,
    output logic [15:0] slot_lock_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    zlac_state_t state_q;
    zlac_state_t state_d;
    logic [7:0] cfg_lock_q;
    logic [7:0] data_lock_q;
    logic [15:0] slot_lock_q;
    logic [15:0] lockable_q;
    zlac_rsp_t code_d;
    logic [7:0] cfg_lock_d;
    logic [7:0] data_lock_d;
    logic [15:0] slot_lock_d;
    logic [15:0] lockable_d;
    zlac_nvwr_t nvwr_d;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic take = req_valid_i && (state_q == ZLAC_ST_READY);
    wire logic cfg_unl = (cfg_lock_q == ZLAC_UNLOCKED); // (R6)
    wire logic data_unl = (data_lock_q == ZLAC_UNLOCKED); // (R11)
    wire logic slot_open = slot_lock_q[req_i.slot]; // (R17)
    wire logic slot_lockable = lockable_q[req_i.slot]; // (R18)
    wire logic is_cfg = (req_i.zone == ZLAC_ZONE_CFG);
    wire logic is_otp = (req_i.zone == ZLAC_ZONE_OTP);
    wire logic is_lock_byte = (req_i.addr == ZLAC_OFS_DATA_LOCK) ||
        (req_i.addr == ZLAC_OFS_CFG_LOCK); // (R1) (R2)
    // (R3) (R9)
    wire logic cfg_wr_ok = cfg_unl && !is_lock_byte &&
        (req_i.addr > ZLAC_OFS_FIXED_LAST); // (R7)
    wire logic wr_slot_lo = (req_i.addr == ZLAC_OFS_SLOT_LO);
    wire logic wr_slot_hi = (req_i.addr == ZLAC_OFS_SLOT_HI);
    wire logic wr_keypol = (req_i.addr >= ZLAC_OFS_KEYPOL) &&
        !req_i.addr[0];
    wire logic [3:0] keypol_slot = req_i.addr[4:1];
    wire logic otp_rd_mode = (otp_mode_i == ZLAC_OTP_READ_ONLY) ||
        (otp_mode_i == ZLAC_OTP_CONSUME);
    wire logic otp_wr_mode = (otp_mode_i == ZLAC_OTP_CONSUME);

    // ------------------------------------------------------------
    // slot lock write-back
    // ------------------------------------------------------------
    // clearing one bit rewrites the whole byte that holds it
    wire logic [15:0] slot_cleared = slot_lock_q &
        ~(16'h0001 << req_i.slot);
    wire logic [6:0] slot_byte_addr = req_i.slot[3] ? ZLAC_OFS_SLOT_HI
        : ZLAC_OFS_SLOT_LO;
    wire logic [7:0] slot_byte_data = req_i.slot[3] ? slot_cleared[15:8]
        : slot_cleared[7:0];

    // ------------------------------------------------------------
    // access decision and lock updates
    // ------------------------------------------------------------
    always_comb
    begin
        code_d = ZLAC_RSP_OK;
        cfg_lock_d = cfg_lock_q;
        data_lock_d = data_lock_q;
        slot_lock_d = slot_lock_q;
        lockable_d = lockable_q;
        nvwr_d = '0;
        case (req_i.op)
            ZLAC_OP_READ:
            begin
                if (is_cfg)
                    code_d = ZLAC_RSP_OK; // (R8)
                else if (cfg_unl || data_unl)
                    code_d = ZLAC_RSP_ERR_LOCK; // (R5) (R11)
                else if (is_otp)
                    code_d = otp_rd_mode ? ZLAC_RSP_OK
                        : ZLAC_RSP_ERR_POLICY; // (R14)
                else
                    code_d = pol_rd_ok_i ? ZLAC_RSP_OK
                        : ZLAC_RSP_ERR_POLICY; // (R13)
            end
            ZLAC_OP_WRITE:
            begin
                if (is_cfg)
                begin
                    if (!cfg_wr_ok)
                        code_d = ZLAC_RSP_ERR_LOCK; // (R7)
                    else
                    begin
                        // plain writes reach slot bits pre-lock only
                        if (wr_slot_lo)
                            slot_lock_d[7:0] = req_i.wdata; // (R16)
                        if (wr_slot_hi)
                            slot_lock_d[15:8] = req_i.wdata; // (R16)
                        if (wr_keypol)
                            lockable_d[keypol_slot] =
                                req_i.wdata[ZLAC_LOCKABLE_BIT]; // (R16)
                    end
                end
                else if (cfg_unl)
                    code_d = ZLAC_RSP_ERR_LOCK; // (R5)
                else if (is_otp)
                    code_d = (data_unl || otp_wr_mode) ? ZLAC_RSP_OK
                        : ZLAC_RSP_ERR_POLICY; // (R14)
                else if (!slot_open)
                    code_d = ZLAC_RSP_ERR_LOCK; // (R17)
                else if (data_unl)
                    code_d = ZLAC_RSP_OK; // (R12)
                else
                    code_d = pol_wr_ok_i ? ZLAC_RSP_OK
                        : ZLAC_RSP_ERR_POLICY; // (R13)
            end
            ZLAC_OP_PRIV_WRITE, ZLAC_OP_GENKEY, ZLAC_OP_DERIVE:
            begin
                if (cfg_unl)
                    code_d = ZLAC_RSP_ERR_LOCK; // (R5)
                else if (!slot_open)
                    code_d = ZLAC_RSP_ERR_LOCK; // (R17)
                else if (data_unl)
                    code_d = ZLAC_RSP_OK; // (R12)
                else
                    code_d = pol_wr_ok_i ? ZLAC_RSP_OK
                        : ZLAC_RSP_ERR_POLICY; // (R13)
            end
            ZLAC_OP_VERIFY:
                code_d = ZLAC_RSP_OK; // (R20)
            ZLAC_OP_LOCK_CFG:
            begin
                if (!cfg_unl)
                    code_d = ZLAC_RSP_ERR_LOCK;
                else
                begin
                    cfg_lock_d = ZLAC_LOCKED; // (R3) (R4)
                    nvwr_d = '{1'b1, ZLAC_OFS_CFG_LOCK, ZLAC_LOCKED};
                end
            end
            ZLAC_OP_LOCK_DATA:
            begin
                // data lock needs config locked first
                if (cfg_unl || !data_unl)
                    code_d = ZLAC_RSP_ERR_LOCK;
                else
                begin
                    data_lock_d = ZLAC_LOCKED; // (R3) (R4)
                    nvwr_d = '{1'b1, ZLAC_OFS_DATA_LOCK, ZLAC_LOCKED};
                end
            end
            ZLAC_OP_LOCK_SLOT:
            begin
                // no content check here; host validates beforehand
                if (cfg_unl)
                    code_d = ZLAC_RSP_ERR_LOCK;
                else if (!slot_open || !slot_lockable)
                    code_d = ZLAC_RSP_ERR_LOCK; // (R18)
                else
                begin
                    slot_lock_d = slot_cleared; // (R10) (R19)
                    nvwr_d = '{1'b1, slot_byte_addr, slot_byte_data};
                end
            end
            default:
                code_d = ZLAC_RSP_ERR_PARAM;
        endcase
    end

    // ------------------------------------------------------------
    // load sequencing
    // ------------------------------------------------------------
    // requests wait out the single load cycle
    always_comb
    begin
        case (state_q)
            ZLAC_ST_LOAD:
                state_d = ZLAC_ST_READY; // (R22)
            ZLAC_ST_READY:
                state_d = ZLAC_ST_READY;
            default:
                state_d = ZLAC_ST_LOAD;
        endcase
    end

    // ------------------------------------------------------------
    // output selection
    // ------------------------------------------------------------
    // answer fields are zero whenever no request was taken
    wire zlac_rsp_t code_out = take ? code_d : ZLAC_RSP_OK;
    wire zlac_nvwr_t nvwr_out = take ? nvwr_d : '0;
    wire logic cfg_locked_d = (cfg_lock_q != ZLAC_UNLOCKED); // (R6)
    wire logic data_locked_d = (data_lock_q != ZLAC_UNLOCKED); // (R11)

    // ------------------------------------------------------------
    // load from storage, then serve requests
    // ------------------------------------------------------------
    // held locked until the image is loaded, so nothing leaks early
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q <= ZLAC_ST_LOAD;
            cfg_lock_q <= ZLAC_RST_LOCK;
            data_lock_q <= ZLAC_RST_LOCK;
            slot_lock_q <= ZLAC_RST_SLOTS;
            lockable_q <= ZLAC_RST_SLOTS;
        end
        else if (state_q == ZLAC_ST_LOAD)
        begin
            state_q <= state_d; // (R22)
            cfg_lock_q <= nv_cfg_lock_i; // (R1)
            data_lock_q <= nv_data_lock_i; // (R2)
            slot_lock_q <= nv_slot_lock_i; // (R15)
            lockable_q <= nv_lockable_i; // (R15)
        end
        else if (take)
        begin
            cfg_lock_q <= cfg_lock_d;
            data_lock_q <= data_lock_d;
            slot_lock_q <= slot_lock_d;
            lockable_q <= lockable_d;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            req_ready_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_code_o <= ZLAC_RSP_OK;
            nv_wr_o <= '0;
        end
        else
        begin
            req_ready_o <= 1'b1;
            rsp_valid_o <= take;
            rsp_code_o <= code_out;
            nv_wr_o <= nvwr_out;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg_locked_o <= 1'b1;
            data_locked_o <= 1'b1;
            slot_lock_o <= ZLAC_RST_SLOTS;
        end
        else
        begin
            cfg_locked_o <= cfg_locked_d; // (R6)
            data_locked_o <= data_locked_d;
            slot_lock_o <= slot_lock_q;
        end
    end

endmodule

/* testbench/zlac_nv_model.sv */
// nonvolatile lock image that the block loads after reset
module zlac_nv_model
    import zlac_pkg::*;
#(
    parameter logic [15:0] SLOTS = 16'h0007,
    parameter logic [15:0] LOCKABLE = 16'h0000
)
(
    // clock and write-back from the block
    input wire logic clk_i,
    input wire zlac_nvwr_t nv_wr_i,
    // stored image
    output logic [7:0] cfg_lock_o,
    output logic [7:0] data_lock_o,
    output logic [15:0] slot_lock_o,
    output logic [15:0] lockable_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------
    // bytes 0x58, 0x59, 0x56, 0x57 by low address bits
    // ------
    logic [7:0] mem_q [4] = '{SLOTS[7:0], SLOTS[15:8], ZLAC_UNLOCKED,
        ZLAC_UNLOCKED};
    // a write survives reset, which is what keeps a lock for good
    always @(posedge clk_i)
    begin
        if (nv_wr_i.we)
            mem_q[nv_wr_i.addr[1:0]] <= nv_wr_i.wdata;
    end
    assign data_lock_o = mem_q[2];
    assign cfg_lock_o = mem_q[3];
    assign slot_lock_o = {mem_q[1], mem_q[0]};
    assign lockable_o = LOCKABLE;
endmodule

/* testbench/zlac_monitor.sv */
// port-level assertions for the zone lock access control
module zlac_monitor
    import zlac_pkg::*;
(
    // clock, reset, request
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire zlac_req_t req_i,
    // answers and status
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire zlac_rsp_t rsp_code_o,
    input wire zlac_nvwr_t nv_wr_o,
    input wire logic cfg_locked_o,
    input wire logic data_locked_o,
    input wire logic [15:0] slot_lock_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------
    // properties
    // ------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // status lags state by an edge, hence the settle guards below
    wire logic tk;
    wire logic op_mod;
    assign tk = req_valid_i && req_ready_o;
    assign op_mod = req_i.op inside {ZLAC_OP_PRIV_WRITE, ZLAC_OP_GENKEY,
        ZLAC_OP_DERIVE};
    property p_answer;
        rsp_valid_o == $past(tk);
    endproperty
    a_answer: assert property (p_answer)
        else $error("answer pulse does not follow request");
    property p_load;
        $fell(rst_i) |-> !req_ready_o ##1 req_ready_o;
    endproperty
    a_load: assert property (p_load)
        else $error("ready not one cycle after reset");
    property p_keep_cfg;
        $past(req_ready_o) && cfg_locked_o |=> cfg_locked_o;
    endproperty
    a_keep_cfg: assert property (p_keep_cfg)
        else $error("config zone unlocked again");
    property p_keep_data;
        $past(req_ready_o) && data_locked_o |=> data_locked_o;
    endproperty
    a_keep_data: assert property (p_keep_data)
        else $error("data zone unlocked again");
    property p_cfg_rd;
        tk && req_i.op == ZLAC_OP_READ && req_i.zone == ZLAC_ZONE_CFG
            |=> rsp_code_o == ZLAC_RSP_OK;
    endproperty
    a_cfg_rd: assert property (p_cfg_rd)
        else $error("config read refused");
    property p_early;
        tk && !cfg_locked_o && !nv_wr_o.we && req_i.zone != ZLAC_ZONE_CFG
            && req_i.op inside {ZLAC_OP_READ, ZLAC_OP_WRITE}
            |=> rsp_code_o == ZLAC_RSP_ERR_LOCK;
    endproperty
    a_early: assert property (p_early)
        else $error("data access before config lock allowed");
    property p_cfg_wr;
        tk && $past(req_ready_o) && cfg_locked_o && req_i.op ==
            ZLAC_OP_WRITE && req_i.zone == ZLAC_ZONE_CFG
            |=> rsp_code_o == ZLAC_RSP_ERR_LOCK;
    endproperty
    a_cfg_wr: assert property (p_cfg_wr)
        else $error("config write after lock allowed");
    property p_slot;
        tk && $past(req_ready_o) && cfg_locked_o && op_mod
            && !slot_lock_o[req_i.slot] |=> rsp_code_o == ZLAC_RSP_ERR_LOCK;
    endproperty
    a_slot: assert property (p_slot)
        else $error("locked slot modified");
    property p_verify;
        tk && req_i.op == ZLAC_OP_VERIFY |=> rsp_code_o == ZLAC_RSP_OK;
    endproperty
    a_verify: assert property (p_verify)
        else $error("verify refused");
    property p_lock_cfg;
        tk && !cfg_locked_o && !nv_wr_o.we && req_i.op == ZLAC_OP_LOCK_CFG
            |=> rsp_code_o == ZLAC_RSP_OK && nv_wr_o.we
            && nv_wr_o.addr == ZLAC_OFS_CFG_LOCK;
    endproperty
    a_lock_cfg: assert property (p_lock_cfg)
        else $error("config lock not written");
    property p_nv_src;
        nv_wr_o.we |-> rsp_valid_o && rsp_code_o == ZLAC_RSP_OK;
    endproperty
    a_nv_src: assert property (p_nv_src)
        else $error("stored write without successful lock");
    cover property (tk && req_i.op == ZLAC_OP_LOCK_SLOT);
    cover property (tk && req_i.op == ZLAC_OP_LOCK_DATA);
    cover property (rsp_valid_o && rsp_code_o == ZLAC_RSP_ERR_POLICY);
endmodule

bind zlac_access_ctrl zlac_monitor zlac_monitor_i (.clk_i, .rst_i,
    .req_valid_i, .req_i, .req_ready_o, .rsp_valid_o, .rsp_code_o,
    .nv_wr_o, .cfg_locked_o, .data_locked_o, .slot_lock_o);

/* testbench/testbench.sv */
// self-checking bench for the zone lock access control
module testbench
    import zlac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ------
    // design, stored image and drivers
    // ------
    localparam zlac_op_t RD = ZLAC_OP_READ, WR = ZLAC_OP_WRITE,
        GK = ZLAC_OP_GENKEY, DV = ZLAC_OP_DERIVE, VF = ZLAC_OP_VERIFY,
        LC = ZLAC_OP_LOCK_CFG, LD = ZLAC_OP_LOCK_DATA, LS = ZLAC_OP_LOCK_SLOT;
    localparam zlac_zone_t C = ZLAC_ZONE_CFG, O = ZLAC_ZONE_OTP,
        D = ZLAC_ZONE_DATA;
    localparam zlac_rsp_t OK = ZLAC_RSP_OK, EL = ZLAC_RSP_ERR_LOCK,
        EP = ZLAC_RSP_ERR_POLICY;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic req_valid_i = 1'h0;
    logic pol_rd_ok_i = 1'h0;
    logic pol_wr_ok_i = 1'h0;
    logic [7:0] otp_mode_i = 8'h00;
    zlac_req_t req_i = '0;
    logic [7:0] nv_cfg_lock_i, nv_data_lock_i;
    logic [15:0] nv_slot_lock_i, nv_lockable_i, slot_lock_o;
    logic req_ready_o, rsp_valid_o, cfg_locked_o, data_locked_o;
    zlac_rsp_t rsp_code_o;
    zlac_nvwr_t nv_wr_o;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    zlac_access_ctrl zlac_access_ctrl_i (.clk_i, .rst_i, .nv_cfg_lock_i,
        .nv_data_lock_i, .nv_slot_lock_i, .nv_lockable_i, .otp_mode_i,
        .pol_rd_ok_i, .pol_wr_ok_i, .req_valid_i, .req_i, .req_ready_o,
        .rsp_valid_o, .rsp_code_o, .nv_wr_o, .cfg_locked_o, .data_locked_o,
        .slot_lock_o);
    zlac_nv_model #(.LOCKABLE(16'h0002)) zlac_nv_model_i (.clk_i,
        .nv_wr_i(nv_wr_o),
        .cfg_lock_o(nv_cfg_lock_i), .data_lock_o(nv_data_lock_i),
        .slot_lock_o(nv_slot_lock_i), .lockable_o(nv_lockable_i));
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 600)
        begin
            failures++;
            conclude();
        end
    end
    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        compares++;
        if (s !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            failures++;
        end
    endtask
    // one request, answered on the same edge that takes it, one edge after it is driven
    task automatic cmd(zlac_op_t op, zlac_zone_t z, logic [3:0] s,
        logic [6:0] a, logic [7:0] d, zlac_rsp_t e, bit ne = 1'h0,
        logic [1:0] p = 2'h0);
        @(posedge clk_i);
        req_valid_i <= 1'h1;
        req_i <= '{op, z, s, a, d};
        {pol_rd_ok_i, pol_wr_ok_i} <= p;
        @(posedge clk_i);
        req_valid_i <= 1'h0;
        #1;
        chk("rsp_valid_o", 16'h1, rsp_valid_o);
        if (ne)
            chk("rsp_error", 16'h1, rsp_code_o != OK);
        else
            chk("rsp_code_o", e, rsp_code_o);
    endtask
    task automatic conclude();
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        cmd(RD, D, '0, '0, '0, EL);
        chk("cfg_locked_o", 16'h0, cfg_locked_o);
        chk("data_locked_o", 16'h0, data_locked_o);
        cmd(WR, O, '0, '0, '0, EL);
        cmd(ZLAC_OP_PRIV_WRITE, D, 4'h1, '0, '0, EL);
        cmd(RD, C, '0, 7'h05, '0, OK);
        cmd(WR, C, '0, 7'h05, '0, EL);
        cmd(WR, C, '0, 7'h57, '0, EL);
        cmd(WR, C, '0, 7'h20, '0, OK);
        cmd(WR, C, '0, 7'h58, 8'h03, OK);
        cmd(WR, C, '0, 7'h59, '0, OK);
        cmd(WR, C, '0, 7'h60, 8'h20, OK);
        cmd(WR, C, '0, 7'h62, 8'h00, OK);
        cmd(LD, C, '0, '0, '0, OK, 1'h1);
        cmd(LC, C, '0, '0, '0, OK);
        chk("nv_wr_o", {1'h1, 7'h57, 8'h00}, nv_wr_o);
        cmd(LC, C, '0, '0, '0, EL);
        cmd(WR, C, '0, 7'h20, '0, EL);
        chk("cfg_locked_o", 16'h1, cfg_locked_o);
        chk("slot_lock_o", 16'h0003, slot_lock_o);
        cmd(RD, D, 4'h1, '0, '0, EL);
        cmd(WR, O, '0, '0, '0, OK);
        cmd(WR, D, 4'h1, '0, '0, OK);
        cmd(LS, D, '0, '0, '0, OK);
        chk("nv_wr_o", {1'h1, 7'h58, 8'h02}, nv_wr_o);
        cmd(LS, D, 4'h1, '0, '0, OK, 1'h1);
        cmd(ZLAC_OP_PRIV_WRITE, D, '0, '0, '0, EL);
        cmd(GK, D, '0, '0, '0, EL);
        cmd(DV, D, 4'h2, '0, '0, EL);
        cmd(WR, D, '0, '0, '0, EL);
        cmd(VF, D, '0, '0, '0, OK);
        cmd(zlac_op_t'(4'h9), C, '0, '0, '0, ZLAC_RSP_ERR_PARAM);
        cmd(LD, C, '0, '0, '0, OK);
        chk("nv_wr_o", {1'h1, 7'h56, 8'h00}, nv_wr_o);
        cmd(RD, D, 4'h1, '0, '0, OK, 1'h0, 2'h2);
        cmd(RD, D, 4'h1, '0, '0, EP);
        cmd(WR, D, 4'h1, '0, '0, EP);
        cmd(WR, D, 4'h1, '0, '0, OK, 1'h0, 2'h1);
        cmd(ZLAC_OP_PRIV_WRITE, D, 4'h1, '0, '0, OK, 1'h0, 2'h1);
        chk("data_locked_o", 16'h1, data_locked_o);
        @(posedge clk_i) otp_mode_i <= 8'haa;
        cmd(RD, O, '0, '0, '0, OK);
        cmd(WR, O, '0, '0, '0, OK, 1'h1);
        @(posedge clk_i) otp_mode_i <= 8'h55;
        cmd(WR, O, '0, '0, '0, OK);
        cmd(RD, O, '0, '0, '0, OK);
        @(posedge clk_i) otp_mode_i <= 8'h11;
        cmd(RD, O, '0, '0, '0, EP);
        @(posedge clk_i);
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        #1;
        chk("req_ready_o", 16'h0, req_ready_o);
        repeat (3) @(posedge clk_i);
        #1;
        chk("req_ready_o", 16'h1, req_ready_o);
        chk("cfg_locked_o", 16'h1, cfg_locked_o);
        chk("data_locked_o", 16'h1, data_locked_o);
        chk("slot_lock_o", 16'h0002, slot_lock_o);
        cmd(LS, D, 4'h1, '0, '0, OK);
        chk("nv_wr_o", {1'h1, 7'h58, 8'h00}, nv_wr_o);
        cmd(WR, D, 4'h1, '0, '0, EL);
        conclude();
    end
endmodule
